// ===== src/bridge_ctrl_consts.vh
`ifndef BRIDGE_CTRL_CONSTS_VH
`define BRIDGE_CTRL_CONSTS_VH

// register byte addresses
`define OFS_CTRL        4'h0
`define OFS_CMD         4'h4
`define OFS_STAT        4'h8

// bridge control field positions
`define BIT_VGA_EN      3
`define BIT_RSVD        4
`define BIT_MA_MODE     5
`define BIT_SEC_RST     6

// command field positions
`define BIT_IO_EN       0
`define BIT_MEM_EN      1
`define BIT_SERR_EN     8

// status field positions
`define BIT_MA_POSTED   0
`define BIT_SEC_ACTIVE  1
`define BIT_LAST_CLAIM  2
`define BIT_LAST_VETO   3

// reset values
`define RST_CTRL        8'h00
`define RST_CMD         9'h000

// legacy video decode windows
`define VGA_MEM_LO      32'h000A0000
`define VGA_MEM_HI      32'h000BFFFF
`define VGA_IO_A_LO     10'h3B0
`define VGA_IO_A_HI     10'h3BB
`define VGA_IO_B_LO     10'h3C0
`define VGA_IO_B_HI     10'h3DF
`define VGA_IO_UPPER    16'h0000

// master abort read return
`define MA_READ_DATA    32'hFFFFFFFF

`endif

// ===== src/pci_bridge_ctrl.v
`timescale 1ns/10ps
`include "bridge_ctrl_consts.vh"

// How it works
// - vga enable claims video transactions regardless of io window, isa, snoop
// - primary memory in legacy video range forwards downstream when enabled
// - primary io hits two video port ranges with upper address zero
// - address bits 15 to 10 ignored, ports alias every 1 KB
// - video forwarding needs both io and memory space enables set
// - video transactions seen on secondary bus are never claimed upstream
// - reserved control bit ignores writes and reads zero
// - master abort mode governs aborts on either interface
// - mode clear completes aborted delayed transaction with normal trdy
// - mode clear returns all ones on reads, no serr on posted writes
// - mode set ends aborted delayed transaction with target abort
// - mode set asserts primary serr on posted write if serr enabled
// - secondary reset bit drives secondary reset output, resets to zero
// - secondary reset holds buffers and secondary logic in reset
// - secondary reset leaves primary logic and config registers alone except the last veto status bit, which it clears
module pci_bridge_ctrl (
    input  wire        SYS_CLK,
    input  wire        RSTN,
    input  wire [3:0]  AVS_ADDRESS,
    input  wire        AVS_READ,
    input  wire        AVS_WRITE,
    input  wire [31:0] AVS_WRITEDATA,
    input  wire [3:0]  AVS_BYTEENABLE,
    output reg  [31:0] AVS_READDATA,
    output reg         AVS_WAITREQUEST,
    input  wire        P_TXN_VALID,
    input  wire [31:0] P_TXN_ADDR,
    input  wire        P_TXN_IO,
    input  wire        P_TXN_MEM,
    output reg         P_CLAIM,
    input  wire        S_TXN_VALID,
    input  wire [31:0] S_TXN_ADDR,
    input  wire        S_TXN_IO,
    input  wire        S_TXN_MEM,
    output reg         S_VETO,
    input  wire        MA_VALID,
    input  wire        MA_POSTED,
    input  wire        MA_READ,
    input  wire        MA_FROM_SEC,
    output reg         DT_TRDY,
    output reg         DT_TABORT,
    output reg         DT_ON_SEC,
    output reg  [31:0] DT_RDATA,
    output reg         P_SERR_N,
    output reg         S_RST_N,
    output reg         BUF_CLR
);

    function vga_io_hit;
        input [31:0] a;
        begin
            // only bits 9..0 and 31..16 take part
            vga_io_hit = (a[31:16] == `VGA_IO_UPPER) &&
                (((a[9:0] >= `VGA_IO_A_LO) && (a[9:0] <= `VGA_IO_A_HI)) ||
                 ((a[9:0] >= `VGA_IO_B_LO) && (a[9:0] <= `VGA_IO_B_HI)));
        end
    endfunction

    function vga_mem_hit;
        input [31:0] a;
        begin
            vga_mem_hit = (a >= `VGA_MEM_LO) && (a <= `VGA_MEM_HI);
        end
    endfunction

    function vga_hit;
        input [31:0] a;
        input        io;
        input        mem;
        begin
            vga_hit = (io && vga_io_hit(a)) || (mem && vga_mem_hit(a));
        end
    endfunction

    reg        vga_en_reg;
    reg        ma_mode_reg;
    reg        sec_rst_reg;
    reg        io_en_reg;
    reg        mem_en_reg;
    reg        serr_en_reg;
    reg        ma_posted_reg;
    reg        last_claim_reg;
    reg        last_veto_reg;

    wire [3:0] word_addr;
    wire       req;
    wire       commit;
    wire       wr_commit;
    wire       hit_ctrl;
    wire       hit_cmd;
    wire       hit_stat;
    reg [31:0] rd_mux;

    assign word_addr = {AVS_ADDRESS[3:2], 2'b00};
    assign req       = AVS_READ | AVS_WRITE;
    // access lands at the edge where the master sees waitrequest low
    assign commit    = req & ~AVS_WAITREQUEST;
    assign wr_commit = commit & AVS_WRITE;
    assign hit_ctrl  = (word_addr == `OFS_CTRL);
    assign hit_cmd   = (word_addr == `OFS_CMD);
    assign hit_stat  = (word_addr == `OFS_STAT);

    always @* begin
        rd_mux = 32'h00000000;
        if (hit_ctrl) begin
            rd_mux[`BIT_VGA_EN]  = vga_en_reg;
            rd_mux[`BIT_RSVD]    = 1'b0;
            rd_mux[`BIT_MA_MODE] = ma_mode_reg;
            rd_mux[`BIT_SEC_RST] = sec_rst_reg;
        end else if (hit_cmd) begin
            rd_mux[`BIT_IO_EN]   = io_en_reg;
            rd_mux[`BIT_MEM_EN]  = mem_en_reg;
            rd_mux[`BIT_SERR_EN] = serr_en_reg;
        end else if (hit_stat) begin
            rd_mux[`BIT_MA_POSTED]  = ma_posted_reg;
            rd_mux[`BIT_SEC_ACTIVE] = sec_rst_reg;
            rd_mux[`BIT_LAST_CLAIM] = last_claim_reg;
            rd_mux[`BIT_LAST_VETO]  = last_veto_reg;
        end
    end

    // bus handshake: one wait cycle, then a single ready cycle
    always @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA    <= 32'h00000000;
        end else if (req && AVS_WAITREQUEST) begin
            AVS_WAITREQUEST <= 1'b0;
            AVS_READDATA    <= AVS_READ ? rd_mux : 32'h00000000;
        end else begin
            AVS_WAITREQUEST <= 1'b1;
        end
    end

    // control bits writable, cleared on device reset
    always @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            vga_en_reg  <= 1'b0;
            ma_mode_reg <= 1'b0;
            sec_rst_reg <= 1'b0;
            io_en_reg   <= 1'b0;
            mem_en_reg  <= 1'b0;
            serr_en_reg <= 1'b0;
        end else if (wr_commit) begin
            if (hit_ctrl && AVS_BYTEENABLE[0]) begin
                vga_en_reg  <= AVS_WRITEDATA[`BIT_VGA_EN];
                ma_mode_reg <= AVS_WRITEDATA[`BIT_MA_MODE];
                sec_rst_reg <= AVS_WRITEDATA[`BIT_SEC_RST];
            end
            if (hit_cmd && AVS_BYTEENABLE[0]) begin
                io_en_reg  <= AVS_WRITEDATA[`BIT_IO_EN];
                mem_en_reg <= AVS_WRITEDATA[`BIT_MEM_EN];
            end
            if (hit_cmd && AVS_BYTEENABLE[1]) begin
                serr_en_reg <= AVS_WRITEDATA[`BIT_SERR_EN];
            end
        end
    end

    // output follows bit; buffers held clear
    always @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            S_RST_N <= 1'b1;
            BUF_CLR <= 1'b0;
        end else begin
            S_RST_N <= ~sec_rst_reg;
            BUF_CLR <= sec_rst_reg;
        end
    end

    wire p_vga;
    wire s_vga;
    wire ma_ok;
    wire clr_posted;
    wire set_posted;

    // no io window, isa or snoop term in this decode
    assign p_vga = P_TXN_VALID & vga_en_reg &
                   vga_hit(P_TXN_ADDR, P_TXN_IO, P_TXN_MEM);
    assign s_vga = S_TXN_VALID & vga_en_reg &
                   vga_hit(S_TXN_ADDR, S_TXN_IO, S_TXN_MEM);

    // primary side is never held by the secondary reset
    always @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            P_CLAIM        <= 1'b0;
            last_claim_reg <= 1'b0;
        end else begin
            P_CLAIM <= p_vga & io_en_reg & mem_en_reg;
            if (P_TXN_VALID) begin
                last_claim_reg <= p_vga & io_en_reg & mem_en_reg;
            end
        end
    end

    // secondary decode
    always @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            S_VETO        <= 1'b0;
            last_veto_reg <= 1'b0;
        end else if (sec_rst_reg) begin
            S_VETO        <= 1'b0;
            last_veto_reg <= 1'b0;
        end else begin
            // video hits on secondary are vetoed upstream
            S_VETO <= s_vga;
            if (S_TXN_VALID) begin
                last_veto_reg <= s_vga;
            end
        end
    end

    // aborts from the secondary side are dropped while it is in reset
    assign ma_ok = MA_VALID & ~(MA_FROM_SEC & sec_rst_reg);

    // one mode bit covers both interfaces
    always @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            DT_TRDY   <= 1'b0;
            DT_TABORT <= 1'b0;
            DT_ON_SEC <= 1'b0;
            DT_RDATA  <= 32'h00000000;
            P_SERR_N  <= 1'b1;
        end else begin
            DT_TRDY   <= 1'b0;
            DT_TABORT <= 1'b0;
            P_SERR_N  <= 1'b1;
            if (ma_ok && !MA_POSTED) begin
                DT_ON_SEC <= MA_FROM_SEC;
                if (ma_mode_reg) begin
                    DT_TABORT <= 1'b1;
                    DT_RDATA  <= 32'h00000000;
                end else begin
                    DT_TRDY  <= 1'b1;
                    DT_RDATA <= MA_READ ? `MA_READ_DATA : 32'h00000000;
                end
            end
            if (ma_ok && MA_POSTED && ma_mode_reg && serr_en_reg) begin
                P_SERR_N <= 1'b0;
            end
        end
    end

    // sticky posted-abort flag, write one to clear, set wins
    assign clr_posted = wr_commit & hit_stat & AVS_BYTEENABLE[0] &
                        AVS_WRITEDATA[`BIT_MA_POSTED];
    assign set_posted = ma_ok & MA_POSTED;

    always @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ma_posted_reg <= 1'b0;
        end else if (set_posted) begin
            ma_posted_reg <= 1'b1;
        end else if (clr_posted) begin
            ma_posted_reg <= 1'b0;
        end
    end

endmodule

// ===== dv/bridge_ctrl_asserts.sv
`timescale 1ns/10ps
module bridge_ctrl_asserts (
    input wire        SYS_CLK,
    input wire        RSTN,
    input wire        P_TXN_VALID,
    input wire [31:0] P_TXN_ADDR,
    input wire        P_TXN_IO,
    input wire        P_TXN_MEM,
    input wire        P_CLAIM,
    input wire        S_TXN_VALID,
    input wire        S_VETO,
    input wire        MA_VALID,
    input wire        MA_POSTED,
    input wire        MA_READ,
    input wire        MA_FROM_SEC,
    input wire        DT_TRDY,
    input wire        DT_TABORT,
    input wire [31:0] DT_RDATA,
    input wire        P_SERR_N,
    input wire        S_RST_N,
    input wire        BUF_CLR
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);
    sequence s_dly_abort;
        MA_VALID && !MA_POSTED && !MA_FROM_SEC;
    endsequence
    sequence s_one_end;
        ##1 (DT_TRDY ^ DT_TABORT);
    endsequence
    a_abort_answered: assert property (s_dly_abort |-> s_one_end)
        else $error("no single completion");
    a_read_ones: assert property (DT_TRDY && $past(MA_READ) |->
        DT_RDATA == 32'hFFFFFFFF) else $error("bad read data");
    a_tabort_zero: assert property (DT_TABORT |-> DT_RDATA == 32'h0)
        else $error("bad abort data");
    a_serr_cause: assert property (!P_SERR_N |->
        $past(MA_VALID && MA_POSTED)) else $error("stray serr");
    a_io_upper: assert property (P_TXN_VALID && P_TXN_IO &&
        !P_TXN_MEM && P_TXN_ADDR[31:16] != 16'h0 |=> !P_CLAIM)
        else $error("io claim");
    a_mem_range: assert property (P_TXN_VALID && P_TXN_MEM && !P_TXN_IO &&
        (P_TXN_ADDR < 32'h000A0000 || P_TXN_ADDR > 32'h000BFFFF)
        |=> !P_CLAIM) else $error("mem claim");
    a_veto_cause: assert property (S_VETO |-> $past(S_TXN_VALID))
        else $error("stray veto");
    a_rst_holds: assert property (!S_RST_N |-> BUF_CLR)
        else $error("buffers free in reset");
endmodule
bind pci_bridge_ctrl bridge_ctrl_asserts chk (.*);

// ===== dv/pci_far_side.sv
`timescale 1ns/10ps
module pci_far_side (
    input  wire         clk,
    output logic        pv = 0,
    output logic [31:0] pa = 32'h0,
    output logic        pio = 0,
    output logic        pm = 0,
    output logic        sv = 0,
    output logic [31:0] sa = 32'h0,
    output logic        sio = 0,
    output logic        sm = 0,
    output logic        mv = 0,
    output logic        mp = 0,
    output logic        mr = 0,
    output logic        ms = 0
);
    // released lines show the inverse, not a stale value
    task txn(input logic s, input logic [31:0] a, input logic io, input logic m);
        @(posedge clk);
        if (s) {sv, sa, sio, sm} <= {1'b1, a, io, m};
        else {pv, pa, pio, pm} <= {1'b1, a, io, m};
        @(posedge clk);
        if (s) {sv, sa, sio, sm} <= {1'b0, ~a, !io, !m};
        else {pv, pa, pio, pm} <= {1'b0, ~a, !io, !m};
    endtask
    task ma(input logic p, input logic r, input logic s);
        @(posedge clk);
        {mv, mp, mr, ms} <= {1'b1, p, r, s};
        @(posedge clk);
        {mv, mp, mr, ms} <= {1'b0, !p, !r, !s};
    endtask
endmodule

// ===== dv/pci_bridge_control_vga_abort_reset_bench.sv
`timescale 1ns/10ps
module pci_bridge_control_vga_abort_reset_bench;
    logic        clk = 0;
    logic        rstn = 0;
    logic [3:0]  adr = 4'h0;
    logic        rd = 0;
    logic        wr = 0;
    logic [31:0] wd = 32'h0;
    logic [31:0] got;
    wire  [31:0] rdat, pa, sa, dtd;
    wire         wq, pv, pio, pm, sv, sio, sm, mv, mp, mr, ms;
    wire         cl, ve, tr, ta, os, se, sr, bc;
    int          err_count = 0;
    int          n_tests = 0;
    int          i;
    int          m;
    localparam logic [31:0] TA [10] = '{32'h3B0, 32'h3BB, 32'h3BC,
        32'h3C0, 32'h3DF, 32'h3E0, 32'hFFC5, 32'h103C5, 32'hA0000, 32'hC0000};
    localparam logic [9:0] TX = 10'h15B;
    always #5 clk = ~clk;
    pci_bridge_ctrl uut (.SYS_CLK(clk), .RSTN(rstn), .AVS_ADDRESS(adr),
        .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd),
        .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wq),
        .P_TXN_VALID(pv), .P_TXN_ADDR(pa), .P_TXN_IO(pio), .P_TXN_MEM(pm),
        .P_CLAIM(cl), .S_TXN_VALID(sv), .S_TXN_ADDR(sa), .S_TXN_IO(sio),
        .S_TXN_MEM(sm), .S_VETO(ve), .MA_VALID(mv), .MA_POSTED(mp),
        .MA_READ(mr), .MA_FROM_SEC(ms), .DT_TRDY(tr), .DT_TABORT(ta),
        .DT_ON_SEC(os), .DT_RDATA(dtd), .P_SERR_N(se), .S_RST_N(sr),
        .BUF_CLR(bc));
    pci_far_side far (.clk(clk), .pv(pv), .pa(pa), .pio(pio), .pm(pm),
        .sv(sv), .sa(sa), .sio(sio), .sm(sm), .mv(mv), .mp(mp), .mr(mr),
        .ms(ms));
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    // request held until waitrequest is seen low at an edge
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        {adr, wd, wr, rd} <= {a, d, w, !w};
        @(posedge clk);
        while (wq !== 1'b0) @(posedge clk);
        got = rdat;
        {wr, rd} <= 2'b00;
    endtask
    task tally_and_finish;
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #200000;
        err_count++;
        tally_and_finish;
    end
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1;
        #1 chk("srst", 32'h1, sr);
        bus(0, 4'h0, 0);
        chk("ctrl", 32'h0, got);
        bus(1, 4'h0, 32'h38);
        bus(0, 4'h0, 0);
        chk("ctrl", 32'h28, got);
        bus(1, 4'h4, 32'h103);
        for (i = 0; i < 10; i++) begin
            far.txn(0, TA[i], i < 8, i >= 8);
            #1 chk("claim", TX[i], cl);
        end
        far.txn(1, 32'h3C5, 1, 0);
        #1 chk("veto", 32'h1, ve);
        for (m = 1; m >= 0; m--) begin
            bus(1, 4'h0, m ? 32'h28 : 32'h08);
            far.ma(0, 1, 0);
            #1 chk("tabort", m, ta);
            chk("trdy", !m, tr);
            chk("rdata", m ? 32'h0 : 32'hFFFFFFFF, dtd);
            far.ma(1, 0, 0);
            #1 chk("serr", !m, se);
            far.ma(0, 0, 1);
            #1 chk("onsec", 32'h1, os);
        end
        bus(1, 4'h0, 32'h28);
        bus(1, 4'h4, 32'h003);
        far.ma(1, 0, 0);
        #1 chk("serr", 32'h1, se);
        bus(1, 4'h0, 32'h48);
        @(posedge clk);
        #1 chk("srst", 32'h0, sr);
        chk("bufclr", 32'h1, bc);
        far.txn(1, 32'h3C5, 1, 0);
        #1 chk("veto", 32'h0, ve);
        bus(0, 4'h4, 0);
        chk("cmd", 32'h003, got);
        bus(1, 4'h4, 32'h103);
        far.txn(0, 32'h3C5, 1, 0);
        #1 chk("claim", 32'h1, cl);
        bus(1, 4'h0, 32'h08);
        @(posedge clk);
        #1 chk("srst", 32'h1, sr);
        bus(0, 4'hC, 0);
        chk("unmapped", 32'h0, got);
        bus(1, 4'h4, 32'h101);
        far.txn(0, 32'hA0000, 0, 1);
        #1 chk("claim", 32'h0, cl);
        bus(0, 4'h8, 0);
        chk("stat", 32'h1, got);
        bus(1, 4'h8, 32'h1);
        bus(0, 4'h8, 0);
        chk("stat", 32'h0, got);
        tally_and_finish;
    end
endmodule
